// ===== design/dsr_acc_shifter.sv
`timescale 1ns/1ns
module dsr_acc_shifter
  import dsr_pkg::*;
(
  input  wire logic [dsr_pkg::ACC_W-1:0] operand,
  output logic      [dsr_pkg::ACC_W-1:0] result,
  output dsr_pkg::dsr_alu_flags_t        flags
);
  always_comb begin
    result  = {{SH8{operand[ACC_W-1]}}, operand[ACC_W-1:SH8]};
    flags.c = operand[SH8-1];
    flags.z = (result == ACC_RST);
    flags.v = 1'b0;  // a right shift cannot leave range
    flags.n = flags.v ^ result[ACC_W-1];
  end
endmodule : dsr_acc_shifter

// ===== design/dsr_accumulator_right_shifter.sv
`timescale 1ns/1ns
module dsr_accumulator_right_shifter
  import dsr_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  input  wire logic                     clk_en,
  input  wire dsr_pkg::dsr_instr_t      instr,
  input  wire logic                     test_flag,
  input  wire dsr_pkg::dsr_load_t       load_req,
  output logic [dsr_pkg::MAC_W-1:0]     mult_acc0,
  output logic [dsr_pkg::MAC_W-1:0]     mult_acc1,
  output logic [dsr_pkg::ACC_W-1:0]     acc0,
  output logic [dsr_pkg::ACC_W-1:0]     acc1,
  output logic [dsr_pkg::ACC_W-1:0]     acc2,
  output logic [dsr_pkg::ACC_W-1:0]     acc3,
  output dsr_pkg::dsr_alu_flags_t       alu_flags,
  output dsr_pkg::dsr_mac_flags_t       mac_flags
);
  import dsr_pkg::*;

  logic [MAC_W-1:0]   mac_q [NMAC];
  logic [ACC_W-1:0]   acc_q [NACC];
  dsr_alu_flags_t     alu_q;
  dsr_mac_flags_t     macf_q;

  logic [MAC_W-1:0]   selected_mult_accumulator;
  logic [MAC_W-1:0]   mac_res;
  logic               guard_overflow_flag_sel;
  logic               guard_bits_ovf;
  logic [ACC_W-1:0]   selected_accumulator;
  logic [ACC_W-1:0]   acc_res;
  dsr_alu_flags_t     acc_flags;
  logic               do_mac;
  logic               do_acc;
  logic               do_load;

  assign selected_mult_accumulator = mac_q[instr.mac_sel];
  assign selected_accumulator      = acc_q[instr.acc_sel];

  assign do_mac = clk_en & instr.valid & (instr.op == DSR_OP_MAC_SHR1);
  // conditional form falls through as a no-op when the test flag is clear
  assign do_acc = clk_en & instr.valid & ((instr.op == DSR_OP_ACC_SHR8) |
                  ((instr.op == DSR_OP_ACC_SHR8_COND) & test_flag));
  // a load gives way to any instruction in the same cycle, so the two never race
  assign do_load = clk_en & load_req.valid & ~instr.valid;

  dsr_mac_shifter u_mac (
    .operand        (selected_mult_accumulator),
    .result         (mac_res),
    .guard_ovf      (guard_overflow_flag_sel),
    .guard_bits_ovf (guard_bits_ovf)
  );

  dsr_acc_shifter u_acc (
    .operand (selected_accumulator),
    .result  (acc_res),
    .flags   (acc_flags)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NMAC; gi++) begin : g_mac
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          mac_q[gi] <= MAC_RST;
        end else if (do_mac && instr.mac_sel == 1'(gi)) begin
          mac_q[gi] <= mac_res;
        end else if (do_load && load_req.to_mac && load_req.sel[0] == 1'(gi)) begin
          mac_q[gi] <= load_req.data;
        end
      end
    end
    for (gi = 0; gi < NACC; gi++) begin : g_acc
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          acc_q[gi] <= ACC_RST;
        end else if (do_acc && instr.acc_sel == 2'(gi)) begin
          acc_q[gi] <= acc_res;
        end else if (do_load && !load_req.to_mac && load_req.sel == 2'(gi)) begin
          acc_q[gi] <= load_req.data[ACC_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      macf_q <= '0;
    end else if (do_mac) begin
      if (instr.mac_sel) begin
        macf_q.guard_overflow_flag_second <= guard_overflow_flag_sel;
      end else begin
        macf_q.guard_overflow_flag_first <= guard_overflow_flag_sel;
      end
      if (guard_bits_ovf) begin
        macf_q.sticky_mult_overflow_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      alu_q <= '0;
    end else if (do_acc) begin
      alu_q <= acc_flags;
    end
  end

  assign mult_acc0 = mac_q[0];
  assign mult_acc1 = mac_q[1];
  assign acc0      = acc_q[0];
  assign acc1      = acc_q[1];
  assign acc2      = acc_q[2];
  assign acc3      = acc_q[3];
  assign alu_flags = alu_q;
  assign mac_flags = macf_q;

  // assertions
  property p_mac_shift;
    @(posedge sys_clk) disable iff (!arst_n)
    do_mac |=> ($past(instr.mac_sel) ? mac_q[1] : mac_q[0]) ==
      {$past(selected_mult_accumulator[MAC_W-1]), $past(selected_mult_accumulator[MAC_W-1:1])};
  endproperty
  a_mac_shift: assert property (p_mac_shift) else $error("mac shift wrong");

  property p_guard_ovf;
    @(posedge sys_clk) disable iff (!arst_n)
    (do_mac && !instr.mac_sel) |=> mac_flags.guard_overflow_flag_first ==
      ($past(selected_mult_accumulator[MAC_W-1:MAC_MSB+1]) != {GUARD_W{
      $past(selected_mult_accumulator[MAC_W-1])}});
  endproperty
  a_guard_ovf: assert property (p_guard_ovf) else $error("guard flag wrong");

  property p_guard_second;
    @(posedge sys_clk) disable iff (!arst_n)
    (do_mac && instr.mac_sel) |=> mac_flags.guard_overflow_flag_second ==
      ($past(selected_mult_accumulator[MAC_W-1:MAC_MSB+1]) != {GUARD_W{
      $past(selected_mult_accumulator[MAC_W-1])}});
  endproperty
  a_guard_second: assert property (p_guard_second) else $error("second guard flag wrong");

  property p_load_mac;
    @(posedge sys_clk) disable iff (!arst_n)
    (do_load && load_req.to_mac) |=>
      ($past(load_req.sel[0]) ? mult_acc1 : mult_acc0) == $past(load_req.data);
  endproperty
  a_load_mac: assert property (p_load_mac) else $error("mult accumulator load wrong");

  property p_load_acc;
    @(posedge sys_clk) disable iff (!arst_n)
    (do_load && !load_req.to_mac && load_req.sel == 2'h3) |=>
      acc3 == $past(load_req.data[ACC_W-1:0]);
  endproperty
  a_load_acc: assert property (p_load_acc) else $error("accumulator load wrong");

  // loads must never disturb the status flags
  property p_load_flags;
    @(posedge sys_clk) disable iff (!arst_n)
    do_load |=> $stable(alu_flags) && $stable(mac_flags);
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("load changed flags");

  property p_freeze;
    @(posedge sys_clk) disable iff (!arst_n)
    !clk_en |=> $stable(alu_flags) && $stable(mac_flags) && $stable(mult_acc0) &&
      $stable(mult_acc1) && $stable(acc0) && $stable(acc1) && $stable(acc2) && $stable(acc3);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_sticky;
    @(posedge sys_clk) disable iff (!arst_n)
    $past(mac_flags.sticky_mult_overflow_flag) |-> mac_flags.sticky_mult_overflow_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag dropped");

  property p_route;
    @(posedge sys_clk) disable iff (!arst_n)
    (do_mac && instr.mac_sel) |=> $stable(mac_flags.guard_overflow_flag_first);
  endproperty
  a_route: assert property (p_route) else $error("flag routed wrong");

  property p_acc_shift;
    @(posedge sys_clk) disable iff (!arst_n)
    (do_acc && instr.acc_sel == 2'h0) |=> acc0 ==
      {{SH8{$past(acc0[ACC_W-1])}}, $past(acc0[ACC_W-1:SH8])};
  endproperty
  a_acc_shift: assert property (p_acc_shift) else $error("acc shift wrong");

  property p_carry;
    @(posedge sys_clk) disable iff (!arst_n)
    do_acc |=> alu_flags.c == $past(selected_accumulator[SH8-1]);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");

  property p_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    do_acc |=> alu_flags.z == ($past(selected_accumulator[ACC_W-1:SH8]) == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_neg;
    @(posedge sys_clk) disable iff (!arst_n)
    do_acc |=> alu_flags.n == (alu_flags.v ^ $past(selected_accumulator[ACC_W-1]))
      && !alu_flags.v;
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");

  property p_cond_skip;
    @(posedge sys_clk) disable iff (!arst_n)
    (clk_en && instr.valid && instr.op == DSR_OP_ACC_SHR8_COND && !test_flag) |=>
      $stable(alu_flags) && $stable(acc0) && $stable(acc1) && $stable(acc2) && $stable(acc3);
  endproperty
  a_cond_skip: assert property (p_cond_skip) else $error("suppressed op changed state");

  c_mac: cover property (@(posedge sys_clk) disable iff (!arst_n) do_mac && instr.mac_sel);
  c_acc: cover property (@(posedge sys_clk) disable iff (!arst_n)
    do_acc && instr.op == DSR_OP_ACC_SHR8_COND);
  c_skip: cover property (@(posedge sys_clk) disable iff (!arst_n)
    instr.valid && instr.op == DSR_OP_ACC_SHR8_COND && !test_flag);
  c_guard: cover property (@(posedge sys_clk) disable iff (!arst_n)
    do_mac && guard_overflow_flag_sel);
  c_load: cover property (@(posedge sys_clk) disable iff (!arst_n) do_load);
endmodule : dsr_accumulator_right_shifter

// ===== design/dsr_mac_shifter.sv
`timescale 1ns/1ns
module dsr_mac_shifter
  import dsr_pkg::*;
(
  input  wire logic [dsr_pkg::MAC_W-1:0] operand,
  output logic      [dsr_pkg::MAC_W-1:0] result,
  output logic                           guard_ovf,
  output logic                           guard_bits_ovf
);
  // arithmetic shift keeps the sign in bit 51
  assign result = {operand[MAC_W-1], operand[MAC_W-1:1]};
  // guard bits plus the product msb must agree, else the value spilled into them
  assign guard_ovf = ~((&result[MAC_W-1:MAC_MSB]) | ~(|result[MAC_W-1:MAC_MSB]));
  // shifting right can never overflow the guard field itself
  assign guard_bits_ovf = operand[MAC_W-1] ^ result[MAC_W-1];
endmodule : dsr_mac_shifter

// ===== design/dsr_pkg.sv
// Behaviour
// - the mult-accumulator shift moves the selected 52-bit mult accumulator right by one bit and writes it back.
// - after that shift the guard overflow flag of the selected mult accumulator is set when the result overflows into the guard bits, else cleared.
// - the sticky mult overflow flag is set when the guard bits themselves overflow and is left alone otherwise.
// - the guard overflow result goes to the first or second flag according to which mult accumulator is selected.
// - the eight-bit shift moves the selected 24-bit accumulator right by eight bits and writes it back.
// - the carry flag takes the last bit shifted out by the eight-bit shift.
// - the zero flag is set when the 24-bit result is zero, else cleared.
// - the overflow flag is set when the shift generates an overflow, else cleared.
// - the negative flag is the exclusive or of the new overflow flag and the result msb.
// - the conditional eight-bit shift executes only while the test flag is set, otherwise nothing happens.
package dsr_pkg;
  localparam int MAC_W   = 52;
  localparam int ACC_W   = 24;
  localparam int GUARD_W = 4;
  localparam int MAC_MSB = 47;
  localparam int SH8     = 8;
  localparam int NACC    = 4;
  localparam int NMAC    = 2;
  localparam logic [MAC_W-1:0] MAC_RST = 52'h0;
  localparam logic [ACC_W-1:0] ACC_RST = 24'h0;

  typedef enum logic [1:0] {
    DSR_OP_NONE,
    DSR_OP_MAC_SHR1,
    DSR_OP_ACC_SHR8,
    DSR_OP_ACC_SHR8_COND
  } dsr_op_t;

  typedef struct packed {
    logic       valid;
    dsr_op_t    op;
    logic       mac_sel;
    logic [1:0] acc_sel;
  } dsr_instr_t;

  // loading port for the accumulators and mult accumulators; without it every accumulator would stay at its reset value
  typedef struct packed {
    logic             valid;
    logic             to_mac;
    logic [1:0]       sel;
    logic [MAC_W-1:0] data;
  } dsr_load_t;

  typedef struct packed {
    logic c;
    logic z;
    logic v;
    logic n;
  } dsr_alu_flags_t;

  typedef struct packed {
    logic guard_overflow_flag_first;
    logic guard_overflow_flag_second;
    logic sticky_mult_overflow_flag;
  } dsr_mac_flags_t;
endpackage : dsr_pkg

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import dsr_pkg::*;
  logic                 sys_clk   = 1'b0;
  logic                 arst_n    = 1'b0;
  logic                 clk_en    = 1'b0;
  dsr_instr_t           instr     = '0;
  logic                 test_flag = 1'b0;
  dsr_load_t            load_req  = '0;
  logic [MAC_W-1:0]     mult_acc0;
  logic [MAC_W-1:0]     mult_acc1;
  logic [ACC_W-1:0]     acc0;
  logic [ACC_W-1:0]     acc1;
  logic [ACC_W-1:0]     acc2;
  logic [ACC_W-1:0]     acc3;
  dsr_alu_flags_t       alu_flags;
  dsr_mac_flags_t       mac_flags;
  logic [MAC_W-1:0]     m_q [NMAC];
  logic [ACC_W-1:0]     a_q [NACC];
  logic [3:0]           af_q;
  logic [2:0]           mf_q;
  logic [31:0]          r;
  logic [7:0]           corner [6] = '{8'hFE, 8'hBB, 8'h2C, 8'hD1, 8'hA8, 8'hB3};
  int                   fail_count = 0;
  int                   checked    = 0;
  int                   seed       = 97248;
  int                   cycles     = 0;

  dsr_accumulator_right_shifter uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .instr(instr),
    .test_flag(test_flag), .load_req(load_req), .mult_acc0(mult_acc0), .mult_acc1(mult_acc1),
    .acc0(acc0), .acc1(acc1), .acc2(acc2), .acc3(acc3),
    .alu_flags(alu_flags), .mac_flags(mac_flags)
  );

  always #10 sys_clk = ~sys_clk;

  // ceiling well above the 1200 checked cycles plus reset
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  function automatic logic [MAC_W-1:0] mac_shr(input logic [MAC_W-1:0] x);
    return MAC_W'($signed(x) >>> 1);
  endfunction : mac_shr

  function automatic logic [ACC_W-1:0] acc_shr(input logic [ACC_W-1:0] x);
    return ACC_W'($signed(x) >>> SH8);
  endfunction : acc_shr

  task automatic check(input logic [MAC_W-1:0] seen, input logic [MAC_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic compare_all();
    check(mult_acc0, m_q[0]);
    check(mult_acc1, m_q[1]);
    check(52'(acc0), 52'(a_q[0]));
    check(52'(acc1), 52'(a_q[1]));
    check(52'(acc2), 52'(a_q[2]));
    check(52'(acc3), 52'(a_q[3]));
    check(52'(alu_flags), 52'(af_q));
    check(52'(mac_flags), 52'(mf_q));
  endtask : compare_all

  task automatic reset_model();
    m_q  = '{default: MAC_RST};
    a_q  = '{default: ACC_RST};
    af_q = 4'h0;
    mf_q = 3'h0;
  endtask : reset_model

  // model update for the inputs that the next rising edge takes
  task automatic apply();
    logic [MAC_W-1:0] mr;
    logic [ACC_W-1:0] ar;
    if (clk_en && instr.valid) begin
      if (instr.op == DSR_OP_MAC_SHR1) begin
        mr = mac_shr(m_q[instr.mac_sel]);
        mf_q[instr.mac_sel ? 1 : 2] = ~(&mr[51:47] | ~|mr[51:47]);
        mf_q[0] = mf_q[0] | (mr[51] ^ m_q[instr.mac_sel][51]);
        m_q[instr.mac_sel] = mr;
      end else if (instr.op == DSR_OP_ACC_SHR8 ||
                   (instr.op == DSR_OP_ACC_SHR8_COND && test_flag)) begin
        ar = acc_shr(a_q[instr.acc_sel]);
        af_q = {a_q[instr.acc_sel][7], ar == 24'h0, 1'b0, ar[23]};
        a_q[instr.acc_sel] = ar;
      end
    end else if (clk_en && load_req.valid) begin
      if (load_req.to_mac)
        m_q[load_req.sel[0]] = load_req.data;
      else
        a_q[load_req.sel] = load_req.data[ACC_W-1:0];
    end
  endtask : apply

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial begin
    reset_model();
    repeat (10) @(negedge sys_clk);
    compare_all();
    arst_n = 1'b1;
    for (int k = 0; k < 1200; k++) begin
      @(negedge sys_clk);
      compare_all();
      if (k == 600) begin
        arst_n = 1'b0;
        reset_model();
        @(negedge sys_clk);
        compare_all();
        arst_n = 1'b1;
      end
      if (k < 6) begin
        {clk_en, test_flag, instr} = corner[k];
      end else begin
        r = $random(seed);
        instr     = r[5:0];
        clk_en    = r[8] | r[9];
        test_flag = r[10];
        load_req.valid  = r[11];
        load_req.to_mac = r[12];
        load_req.sel    = r[14:13];
        load_req.data   = 52'({$random(seed), $random(seed)});
      end
      apply();
    end
    @(negedge sys_clk);
    compare_all();
    complete_run();
  end
endmodule : tb_top
